/* File: mia_core.v */
// Maskable interrupt acceptance with context save and return, AHB-Lite slave
`timescale 1ns/10ps
`include "mia_defs.vh"

module mia_core (
    // Clock and reset
    input  wire        clk_in,
    input  wire        rst_n_in,
    // AHB-Lite slave
    input  wire        hsel_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output reg  [31:0] hrdata_out,
    output reg         hreadyout_out,
    output reg         hresp_out,
    // Peripheral requests, one pulse or level per source
    input  wire [7:0]  irq_in,
    // Stack write port
    output reg         stk_we_out,
    output reg  [15:0] stk_addr_out,
    output reg  [7:0]  stk_wdata_out,
    // Status of acceptance
    output reg         irq_taken_out,
    output reg  [2:0]  irq_src_out
);

    localparam ST_IDLE = 4'b0001;
    localparam ST_SAVE = 4'b0010;
    localparam ST_LOAD = 4'b0100;
    localparam ST_RET  = 4'b1000;

    reg  [7:0]  req_flag;
    reg  [7:0]  source_mask_flag;
    reg  [7:0]  priority_select_flag;
    reg         global_irq_enable;
    reg         in_service_priority;
    reg  [15:0] pc;
    reg  [15:0] sp;
    reg  [15:0] vec_base;
    reg         div_busy;
    reg  [3:0]  state;
    reg  [2:0]  step;
    reg  [2:0]  cur_src;
    reg  [7:0]  saved_status;
    reg  [15:0] saved_pc;
    reg  [7:0]  pop_status;
    reg  [15:0] pop_pc;
    reg  [5:0]  pend_cnt;

    reg         ap_valid;
    reg         ap_write;
    reg  [7:0]  ap_addr;

    wire [7:0]  status_word;
    wire [7:0]  eligible;
    wire [7:0]  hi_cand;
    wire [7:0]  cand;
    wire [2:0]  win;
    wire        win_prio;
    wire        can_take;
    wire        bus_start;

    // Lowest index wins: default priority order
    function [2:0] mia_first;
        input [7:0] v;
        integer i;
        begin
            mia_first = 3'd0;
            for (i = 7; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    mia_first = i[2:0];
                end
            end
        end
    endfunction

    assign status_word = {global_irq_enable, 5'b0_0000, in_service_priority, 1'b0};

    assign eligible = req_flag & ~source_mask_flag;
    assign hi_cand  = eligible & ~priority_select_flag;
    assign cand     = (hi_cand != 8'h00) ? hi_cand : eligible;
    assign win      = mia_first(cand);
    assign win_prio = priority_select_flag[win];
    // acceptance gate; pending kept until true
    assign can_take = (eligible != 8'h00) && global_irq_enable && !div_busy &&
                      (in_service_priority || !win_prio);

    assign bus_start = hsel_in && hready_in && htrans_in[1];

    // AHB-Lite address phase capture, zero wait states
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr  <= 8'h00;
        end else if (hready_in) begin
            ap_valid <= bus_start;
            ap_write <= hwrite_in;
            ap_addr  <= haddr_in[7:0];
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            hrdata_out    <= 32'h0000_0000;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            hrdata_out    <= 32'h0000_0000;
            if (bus_start && !hwrite_in) begin
                case (haddr_in[7:0])
                    `MIA_OFF_REQ:     hrdata_out <= {24'h00_0000, req_flag};
                    `MIA_OFF_MASK:    hrdata_out <= {24'h00_0000, source_mask_flag};
                    `MIA_OFF_PRIO:    hrdata_out <= {24'h00_0000, priority_select_flag};
                    `MIA_OFF_CTRL:    hrdata_out <= {30'h0000_0000, in_service_priority,
                                                     global_irq_enable};
                    `MIA_OFF_PC:      hrdata_out <= {16'h0000, pc};
                    `MIA_OFF_SP:      hrdata_out <= {16'h0000, sp};
                    `MIA_OFF_STAT:    hrdata_out <= {23'h00_0000, cur_src, state, 1'b0,
                                                     ~state[0]};
                    `MIA_OFF_VBASE:   hrdata_out <= {16'h0000, vec_base};
                    `MIA_OFF_DIVBUSY: hrdata_out <= {31'h0000_0000, div_busy};
                    default:          hrdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Sequencer, flags and registers share one process so each has one driver
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_flag             <= 8'h00;
            source_mask_flag     <= `MIA_RST_MASK;
            priority_select_flag <= `MIA_RST_PRIO;
            global_irq_enable    <= 1'b0;
            in_service_priority  <= 1'b1;
            pc                   <= 16'h0000;
            sp                   <= `MIA_RST_SP;
            vec_base             <= `MIA_RST_VBASE;
            div_busy             <= 1'b0;
            state                <= ST_IDLE;
            step                 <= 3'd0;
            cur_src              <= 3'd0;
            saved_status         <= 8'h00;
            saved_pc             <= 16'h0000;
            pop_status           <= 8'h00;
            pop_pc               <= 16'h0000;
            stk_we_out           <= 1'b0;
            stk_addr_out         <= 16'h0000;
            stk_wdata_out        <= 8'h00;
            irq_taken_out        <= 1'b0;
            irq_src_out          <= 3'd0;
        end else begin
            stk_we_out    <= 1'b0;
            irq_taken_out <= 1'b0;
            if (ap_valid && ap_write) begin
                case (ap_addr)
                    `MIA_OFF_REQ:     req_flag <= hwdata_in[7:0];
                    `MIA_OFF_MASK:    source_mask_flag <= hwdata_in[7:0];
                    `MIA_OFF_PRIO:    priority_select_flag <= hwdata_in[7:0];
                    `MIA_OFF_CTRL: begin
                        global_irq_enable   <= hwdata_in[`MIA_CTRL_IE];
                        in_service_priority <= hwdata_in[`MIA_CTRL_ISP];
                    end
                    `MIA_OFF_PC:      pc <= hwdata_in[15:0];
                    `MIA_OFF_SP:      sp <= hwdata_in[15:0];
                    `MIA_OFF_VBASE:   vec_base <= hwdata_in[15:0];
                    `MIA_OFF_DIVBUSY: div_busy <= hwdata_in[0];
                    default:          ;
                endcase
            end
            // New requests set after any software write, so a set wins
            req_flag <= ((ap_valid && ap_write && ap_addr == `MIA_OFF_REQ) ?
                         hwdata_in[7:0] : req_flag) | irq_in;
            case (state)
                ST_IDLE: begin
                    if (ap_valid && ap_write && ap_addr == `MIA_OFF_CMD &&
                        hwdata_in == `MIA_CMD_RETURN_FROM_IRQ_INSTR) begin
                        state <= ST_RET;
                        step  <= 3'd0;
                    end else if (can_take) begin
                        global_irq_enable   <= 1'b0;
                        in_service_priority <= win_prio;
                        saved_status        <= status_word;
                        saved_pc            <= pc;
                        cur_src             <= win;
                        req_flag[win]       <= irq_in[win];
                        state               <= ST_SAVE;
                        step                <= 3'd0;
                    end
                end
                ST_SAVE: begin
                    // status word, then PC high, then PC low
                    stk_we_out <= 1'b1;
                    case (step)
                        3'd0: begin
                            stk_addr_out  <= sp - 16'h0001;
                            stk_wdata_out <= saved_status;
                        end
                        3'd1: begin
                            stk_addr_out  <= sp - 16'h0002;
                            stk_wdata_out <= saved_pc[15:8];
                        end
                        default: begin
                            stk_addr_out  <= sp - 16'h0003;
                            stk_wdata_out <= saved_pc[7:0];
                            sp            <= sp - 16'h0003;
                            state         <= ST_LOAD;
                        end
                    endcase
                    step <= step + 3'd1;
                end
                ST_LOAD: begin
                    pc            <= vec_base + {12'h000, cur_src, 1'b0};
                    irq_taken_out <= 1'b1;
                    irq_src_out   <= cur_src;
                    state         <= ST_IDLE;
                end
                ST_RET: begin
                    case (step)
                        3'd0: pop_pc <= saved_pc;
                        3'd1: pop_status <= saved_status;
                        default: begin
                            pc                  <= saved_pc;
                            global_irq_enable   <= saved_status[`MIA_STATUS_IE];
                            in_service_priority <= saved_status[`MIA_STATUS_ISP];
                            sp                  <= sp + 16'h0003;
                            state               <= ST_IDLE;
                        end
                    endcase
                    step <= step + 3'd1;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule

/* File: mia_core_asserts.sv */
// Port-level checks for the acceptance block
`timescale 1ns/10ps
module mia_core_asserts (
    input wire        clk_in,
    input wire        rst_n_in,
    input wire        hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0]  htrans_in,
    input wire        hwrite_in,
    input wire        hready_in,
    input wire [31:0] hrdata_out,
    input wire        hreadyout_out,
    input wire        hresp_out,
    input wire        stk_we_out,
    input wire [15:0] stk_addr_out,
    input wire [7:0]  stk_wdata_out,
    input wire        irq_taken_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire rd_ph = hsel_in & hready_in & htrans_in[1] & ~hwrite_in;
    wire hole = (haddr_in >= 32'h0000_0028) && (haddr_in < 32'h0000_0100);
    bus_okay_a: assert property (hreadyout_out && !hresp_out)
        else $error("bus answer not ready or not okay");
    upper_zero_a: assert property (rd_ph |=> hrdata_out[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    unmapped_read_a: assert property (rd_ph && hole |=> hrdata_out == 32'h0000_0000)
        else $error("unmapped read not zero");
    push_three_a: assert property ($rose(stk_we_out) |-> stk_we_out[*3] ##1 !stk_we_out)
        else $error("context save not three writes");
    push_down_a: assert property (stk_we_out && $past(stk_we_out) |->
        stk_addr_out == $past(stk_addr_out) - 16'h0001)
        else $error("stack writes not descending");
    enable_saved_a: assert property ($rose(stk_we_out) |-> stk_wdata_out[7])
        else $error("saved status lacks global enable");
    vector_after_a: assert property ($fell(stk_we_out) |-> irq_taken_out)
        else $error("vector load not right after save");
    taken_pulse_a: assert property (irq_taken_out |=> !irq_taken_out)
        else $error("taken pulse longer than one cycle");
    cover property ($rose(irq_taken_out));
    cover property (stk_we_out[*3]);
    cover property (rd_ph && hole);
endmodule
bind mia_core mia_core_asserts i_mia_core_asserts (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .stk_we_out(stk_we_out), .stk_addr_out(stk_addr_out),
    .stk_wdata_out(stk_wdata_out), .irq_taken_out(irq_taken_out));

/* File: mia_core_tb.sv */
// Self-checking bench for the acceptance block
`timescale 1ns/10ps
`include "mia_defs.vh"
module mia_core_tb;
    logic        clk_in = 0;
    logic        rst_n_in = 0;
    logic        hsel_in = 0;
    logic [31:0] haddr_in = 0;
    logic [1:0]  htrans_in = 0;
    logic        hwrite_in = 0;
    logic [31:0] hwdata_in = 0;
    logic [7:0]  fire = 0;
    wire  [7:0]  irq_in;
    wire  [31:0] hrdata_out;
    wire         hreadyout_out, hresp_out, stk_we_out, irq_taken_out;
    wire  [15:0] stk_addr_out;
    wire  [7:0]  stk_wdata_out;
    wire  [2:0]  irq_src_out;
    int          mismatches = 0, n_checks = 0, cyc = 0;
    logic [31:0] rd;
    // Rows: mask, priority flags, requests, expected source
    logic [31:0] rows [0:4] = '{32'h00FF_0100, 32'h00FF_1803, 32'h00EF_1804,
                                32'h007F_8007, 32'h08FF_1804};
    always #2.5 clk_in = ~clk_in;
    mia_core i_mia_core (.clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in),
        .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'b010),
        .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .irq_in(irq_in),
        .stk_we_out(stk_we_out), .stk_addr_out(stk_addr_out), .stk_wdata_out(stk_wdata_out),
        .irq_taken_out(irq_taken_out), .irq_src_out(irq_src_out));
    mia_stack_model i_mia_stack_model (.clk_in(clk_in), .stk_we_in(stk_we_out),
        .stk_addr_in(stk_addr_out), .stk_wdata_in(stk_wdata_out), .fire_in(fire),
        .irq_out(irq_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        hsel_in <= 1'b1;
        htrans_in <= 2'b10;
        haddr_in <= {24'h00_0000, a};
        hwrite_in <= w;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'b00;
        hwdata_in <= d;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
        hsel_in <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    task automatic raise(input logic [7:0] p);
        @(posedge clk_in);
        fire <= p;
        @(posedge clk_in);
        fire <= 8'h00;
    endtask
    // Waits for a taken pulse, giving up after lim cycles
    task automatic wait_take(input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
        end while (irq_taken_out !== 1'b1 && n < lim);
    endtask
    task automatic service(input logic [2:0] s, input logic pb);
        wait_take(32 + pb);
        chk({31'h0, irq_taken_out}, 32'h1);
        chk({29'h0, irq_src_out}, {29'h0, s});
        rdchk(`MIA_OFF_PC, 32'h4 + 2 * s);
        rdchk(`MIA_OFF_CTRL, {30'h0, pb, 1'b0});
        for (int k = 0; k < 3; k++) begin
            chk(i_mia_stack_model.log_addr[k], 32'h0000_FEDF - k);
        end
        chk(i_mia_stack_model.log_data[0] & 8'h82, 32'h82);
        chk({i_mia_stack_model.log_data[1], i_mia_stack_model.log_data[2]}, 32'h0);
        i_mia_stack_model.log_addr.delete();
        i_mia_stack_model.log_data.delete();
    endtask
    task automatic ret_chk;
        bus(1'b1, `MIA_OFF_CMD, `MIA_CMD_RETURN_FROM_IRQ_INSTR);
        repeat (4) @(posedge clk_in);
        rdchk(`MIA_OFF_PC, 32'h0);
        rdchk(`MIA_OFF_CTRL, 32'h3);
        rdchk(`MIA_OFF_SP, 32'h0000_FEE0);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Whole run is a few hundred cycles
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            results;
        end
    end
    initial begin
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int r = 0; r < 5; r++) begin
            bus(1'b1, `MIA_OFF_MASK, {24'h0, rows[r][31:24]});
            bus(1'b1, `MIA_OFF_PRIO, {24'h0, rows[r][23:16]});
            bus(1'b1, `MIA_OFF_CTRL, 32'h3);
            raise(rows[r][15:8]);
            service(rows[r][2:0], rows[r][16 + rows[r][2:0]]);
            // Drop unmasked losers so a restored enable cannot take them mid-check
            bus(1'b1, `MIA_OFF_REQ, {24'h0, rows[r][31:24] & rows[r][15:8]});
            ret_chk;
        end
        // Masked source three still pending
        bus(1'b1, `MIA_OFF_MASK, 32'h0);
        service(3'd3, 1'b1);
        ret_chk;
        bus(1'b1, `MIA_OFF_CTRL, 32'h2);
        raise(8'h01);
        wait_take(40);
        chk({31'h0, irq_taken_out}, 32'h0);
        bus(1'b1, `MIA_OFF_CTRL, 32'h3);
        service(3'd0, 1'b1);
        ret_chk;
        bus(1'b1, `MIA_OFF_DIVBUSY, 32'h1);
        raise(8'h02);
        wait_take(40);
        chk({31'h0, irq_taken_out}, 32'h0);
        bus(1'b1, `MIA_OFF_DIVBUSY, 32'h0);
        service(3'd1, 1'b1);
        ret_chk;
        bus(1'b1, `MIA_OFF_PRIO, 32'h7F);
        raise(8'h80);
        service(3'd7, 1'b0);
        bus(1'b1, `MIA_OFF_CTRL, 32'h1);
        raise(8'h02);
        wait_take(40);
        chk({31'h0, irq_taken_out}, 32'h0);
        bus(1'b1, `MIA_OFF_CMD, `MIA_CMD_RETURN_FROM_IRQ_INSTR);
        service(3'd1, 1'b1);
        ret_chk;
        bus(1'b1, 8'h30, 32'hFFFF_FFFF);
        rdchk(8'h30, 32'h0);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rdchk(`MIA_OFF_MASK, 32'hFF);
        rdchk(`MIA_OFF_CTRL, 32'h2);
        rdchk(`MIA_OFF_SP, 32'hFEE0);
        rdchk(`MIA_OFF_VBASE, 32'h4);
        results;
    end
endmodule

/* File: mia_defs.vh */
// Constants for the maskable interrupt acknowledge block
`ifndef MIA_DEFS_VH
`define MIA_DEFS_VH

`define MIA_NSRC            8
// Register byte offsets
`define MIA_OFF_REQ         8'h00
`define MIA_OFF_MASK        8'h04
`define MIA_OFF_PRIO        8'h08
`define MIA_OFF_CTRL        8'h0C
`define MIA_OFF_PC          8'h10
`define MIA_OFF_SP          8'h14
`define MIA_OFF_CMD         8'h18
`define MIA_OFF_STAT        8'h1C
`define MIA_OFF_VBASE       8'h20
`define MIA_OFF_DIVBUSY     8'h24
// Control and saved status bit positions
`define MIA_CTRL_IE         0
`define MIA_CTRL_ISP        1
`define MIA_STATUS_ISP      1
`define MIA_STATUS_IE       7
// Command codes
`define MIA_CMD_RETURN_FROM_IRQ_INSTR        32'h0000_0001
// Reset values
`define MIA_RST_MASK        8'hFF
`define MIA_RST_PRIO        8'hFF
`define MIA_RST_SP          16'hFEE0
`define MIA_RST_VBASE       16'h0004
// Timing: acceptance sequence length
`define MIA_LAT_MIN_CLK     7
`define MIA_LAT_MAX_CLK     32
`define MIA_SEQ_CLK         6
`define MIA_ACC_CLK         5

`endif

/* File: mia_stack_model.sv */
// Far side: peripheral request sources and a log of stack writes
`timescale 1ns/10ps
module mia_stack_model (
    // Clock
    input  wire        clk_in,
    // Stack write port
    input  wire        stk_we_in,
    input  wire [15:0] stk_addr_in,
    input  wire [7:0]  stk_wdata_in,
    // Requests asked for by the bench
    input  wire [7:0]  fire_in,
    output logic [7:0] irq_out
);
    logic [15:0] log_addr[$];
    logic [7:0]  log_data[$];
    initial irq_out = 8'h00;
    // Sources pulse for one clock, so only the sticky flag keeps them
    always @(posedge clk_in) begin
        irq_out <= fire_in;
        if (stk_we_in === 1'b1) begin
            log_addr.push_back(stk_addr_in);
            log_data.push_back(stk_wdata_in);
        end
    end
endmodule
